// ---- logic/i2cto_buf.sv ----
// two-entry buffer on the register write stream
// assumes synchronous active-high reset and a freezing clock enable
`timescale 1ns/1ps
module i2cto_buf
(
  input  wire logic   i_clk,
  input  wire logic   i_srst,
  input  wire logic   i_ce,
  i2cto_buf_if.fifo   bif
);

  typedef struct packed {
    logic                          v0;
    logic                          v1;
    logic [i2cto_pkg::ENTRY_W-1:0] d0;
    logic [i2cto_pkg::ENTRY_W-1:0] d1;
  } i2cto_buf_st_t;

  i2cto_buf_st_t s_r;
  i2cto_buf_st_t s_nxt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (s_r.v0 && bif.out_ready)
    begin
      s_nxt.d0 = s_r.d1;
      s_nxt.v0 = s_r.v1;
      s_nxt.v1 = 1'b0;
    end
    // full means in_ready low, so a push never overwrites
    if (bif.in_valid && !s_r.v1)
    begin
      if (!s_nxt.v0)
      begin
        s_nxt.d0 = bif.in_data;
        s_nxt.v0 = 1'b1;
      end
      else
      begin
        s_nxt.d1 = bif.in_data;
        s_nxt.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      s_r <= '0;
    else if (i_ce)
      s_r <= s_nxt;
  end

  assign bif.in_ready  = ~s_r.v1;
  assign bif.out_valid = s_r.v0;
  assign bif.out_data  = s_r.d0;

endmodule : i2cto_buf

// ---- logic/i2cto_buf_if.sv ----
// write-stream carrier between the protocol engine and its two-entry buffer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface i2cto_buf_if;
  logic                              in_valid;
  logic                              in_ready;
  logic [i2cto_pkg::ENTRY_W-1:0]     in_data;
  logic                              out_valid;
  logic                              out_ready;
  logic [i2cto_pkg::ENTRY_W-1:0]     out_data;

  modport prod (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface : i2cto_buf_if

// ---- logic/i2cto_pkg.sv ----
// constants and state codes of the two-wire target with bus timeout
// assumes a 10 MHz core clock and a bus controller that owns the serial clock
//
// Contract
// - answer at A2h/A3h, up to 400 kHz
// - one bit per clock, data stable high
// - idle bus has both lines released high
// - start is data falling while clock high
// - stop is data rising while clock high
// - repeated start acts as stop plus start
// - open 950 ms or more clears interface
// - after timeout no ack, reads give FFh
// - pointer survives stop and timeout
// - eight-bit bytes plus receiver's ninth ack
// - no byte limit within one transaction
// - first byte after start is address
// - clock input only, data driven both ways
// - acknowledge every byte received as receiver; code nacks a data byte while the write buffer is full
// - ack holds data low through clock high
// - on controller nack, release data line
// - ack only target address 1010001b
// - first write byte sets pointer, then increments
// - bare read continues from pointer, incrementing
// - backup power releases and resets interface
package i2cto_pkg;

  // ----------------------------------------
  // bus identity and data widths
  // ----------------------------------------
  localparam logic [6:0]  TARGET_ADDR  = 7'h51;
  localparam int          SCL_MAX_KHZ  = 400;
  localparam logic [7:0]  IDLE_BYTE    = 8'hFF;
  localparam int          BYTE_W       = 8;
  localparam int          ENTRY_W      = 16;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          TOUT_MS      = 950;
  localparam int          TOUT_CYCLES  = TOUT_MS * (CLK_HZ / 1000);
  localparam int          TMO_W        = 24;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0]  PTR_RST      = 8'h00;
  localparam logic [2:0]  BIT_RST      = 3'h0;

  // ----------------------------------------
  // protocol states
  // ----------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ADDR   = 8'h02,
    ST_RX     = 8'h04,
    ST_ACKW   = 8'h08,
    ST_ACK    = 8'h10,
    ST_TX     = 8'h20,
    ST_MACK   = 8'h40,
    ST_IGNORE = 8'h80
  } i2cto_state_t;

endpackage : i2cto_pkg

// ---- logic/i2cto_target.sv ----
// two-wire bus target with transaction timeout, register pointer and write stream
// assumes the serial lines and backup flag are asynchronous, read data from core logic
`timescale 1ns/1ps
module i2cto_target
#(
  parameter int unsigned TIMEOUT_CYCLES = i2cto_pkg::TOUT_CYCLES
)
(
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_CE,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output logic             O_SDA,
  output logic             O_SDA_OE,
  input  wire logic        I_BACKUP_POWER_STATE,
  output logic             O_WR_VALID,
  output logic [7:0]       O_WR_ADDR,
  output logic [7:0]       O_WR_DATA,
  input  wire logic        I_WR_READY,
  output logic             O_RD_REQ,
  output logic [7:0]       O_RD_ADDR,
  input  wire logic        I_RD_VALID,
  input  wire logic [7:0]  I_RD_DATA
);

  // ----------------------------------------
  // state record
  // ----------------------------------------
  typedef struct packed {
    logic                            scl_m;
    logic                            scl_s;
    logic                            scl_p;
    logic                            sda_m;
    logic                            sda_s;
    logic                            sda_p;
    logic                            bk_m;
    logic                            bk_s;
    i2cto_pkg::i2cto_state_t         st;
    logic [2:0]                      bit_cnt;
    logic [7:0]                      sh;
    logic                            rd_dir;
    logic                            first;
    logic                            ack_go;
    logic [7:0]                      ptr;
    logic [7:0]                      rd_data;
    logic                            rd_have;
    logic [i2cto_pkg::TMO_W-1:0]     tmo;
    logic                            sda_oe;
    logic                            sda_o;
    logic                            rd_req;
    logic [7:0]                      rd_addr;
  } i2cto_state_rec_t;

  localparam i2cto_state_rec_t RST_REC = '{
    scl_m:   1'b1,
    scl_s:   1'b1,
    scl_p:   1'b1,
    sda_m:   1'b1,
    sda_s:   1'b1,
    sda_p:   1'b1,
    bk_m:    1'b0,
    bk_s:    1'b0,
    st:      i2cto_pkg::ST_IDLE,
    bit_cnt: i2cto_pkg::BIT_RST,
    sh:      8'h00,
    rd_dir:  1'b0,
    first:   1'b0,
    ack_go:  1'b0,
    ptr:     i2cto_pkg::PTR_RST,
    rd_data: i2cto_pkg::IDLE_BYTE,
    rd_have: 1'b0,
    tmo:     '0,
    sda_oe:  1'b0,
    sda_o:   1'b0,
    rd_req:  1'b0,
    rd_addr: i2cto_pkg::PTR_RST
  };

  localparam logic [i2cto_pkg::TMO_W-1:0] TMO_LAST =
    i2cto_pkg::TMO_W'(TIMEOUT_CYCLES - 1);

  i2cto_state_rec_t s_r;
  i2cto_state_rec_t s_nxt;

  i2cto_buf_if bif ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] b);
    addr_hit = (b[7:1] == i2cto_pkg::TARGET_ADDR);
  endfunction : addr_hit

  // loads the next transmit byte; a missing answer shifts out the idle byte
  function automatic i2cto_state_rec_t load_tx(input i2cto_state_rec_t c);
    i2cto_state_rec_t r;
    logic [7:0]       b;
    r = c;
    b = c.rd_have ? c.rd_data : i2cto_pkg::IDLE_BYTE;
    r.sda_oe  = ~b[7];
    r.sh      = {b[6:0], 1'b0};
    r.bit_cnt = i2cto_pkg::BIT_RST;
    r.st      = i2cto_pkg::ST_TX;
    r.ptr     = c.ptr + 8'h01;
    r.rd_req  = 1'b1;
    r.rd_addr = c.ptr + 8'h01;
    r.rd_have = 1'b0;
    load_tx = r;
  endfunction : load_tx

  // ----------------------------------------
  // line events
  // ----------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [7:0] byte_in;
  logic       push;

  always_comb
  begin
    scl_rise  = s_r.scl_s & ~s_r.scl_p;
    scl_fall  = ~s_r.scl_s & s_r.scl_p;
    start_det = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
    stop_det  = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
    byte_in   = {s_r.sh[6:0], s_r.sda_s};
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt        = s_r;
    push         = 1'b0;
    s_nxt.rd_req = 1'b0;
    s_nxt.sda_o  = 1'b0;

    // first stage feeds only the second
    s_nxt.scl_m = I_SCL;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = I_SDA;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.bk_m  = I_BACKUP_POWER_STATE;
    s_nxt.bk_s  = s_r.bk_m;

    if (I_RD_VALID)
    begin
      s_nxt.rd_data = I_RD_DATA;
      s_nxt.rd_have = 1'b1;
    end

    if (s_r.bk_s)
    begin
      // held in reset while on backup supply; pointer kept
      s_nxt.st      = i2cto_pkg::ST_IDLE;
      s_nxt.sda_oe  = 1'b0;
      s_nxt.tmo     = '0;
      s_nxt.bit_cnt = i2cto_pkg::BIT_RST;
    end
    else if (start_det)
    begin
      // a repeated start simply restarts the address phase
      s_nxt.st      = i2cto_pkg::ST_ADDR;
      s_nxt.bit_cnt = i2cto_pkg::BIT_RST;
      s_nxt.sda_oe  = 1'b0;
      s_nxt.tmo     = '0;
      s_nxt.first   = 1'b1;
    end
    else if (stop_det)
    begin
      s_nxt.st     = i2cto_pkg::ST_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.tmo    = '0;
    end
    else if (s_r.st != i2cto_pkg::ST_IDLE && s_r.st != i2cto_pkg::ST_IGNORE
             && s_r.tmo == TMO_LAST)
    begin
      // released line means no ack on writes and FFh on reads
      s_nxt.st     = i2cto_pkg::ST_IGNORE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.tmo    = '0;
    end
    else
    begin
      if (s_r.st != i2cto_pkg::ST_IDLE && s_r.st != i2cto_pkg::ST_IGNORE)
        s_nxt.tmo = s_r.tmo + i2cto_pkg::TMO_W'(1);

      unique case (s_r.st)
        i2cto_pkg::ST_IDLE:
        begin
          s_nxt.sda_oe = 1'b0;
        end

        i2cto_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            s_nxt.sh      = byte_in;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7)
            begin
              s_nxt.st     = i2cto_pkg::ST_ACKW;
              s_nxt.ack_go = addr_hit(byte_in);
              s_nxt.rd_dir = byte_in[0];
              if (addr_hit(byte_in) && byte_in[0])
              begin
                s_nxt.rd_req  = 1'b1;
                s_nxt.rd_addr = s_r.ptr;
                s_nxt.rd_have = 1'b0;
              end
            end
          end
        end

        i2cto_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            s_nxt.sh      = byte_in;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7)
            begin
              s_nxt.st = i2cto_pkg::ST_ACKW;
              if (s_r.first)
              begin
                s_nxt.ptr    = byte_in;
                s_nxt.first  = 1'b0;
                s_nxt.ack_go = 1'b1;
              end
              else if (bif.in_ready)
              begin
                push         = 1'b1;
                s_nxt.ptr    = s_r.ptr + 8'h01;
                s_nxt.ack_go = 1'b1;
              end
              else
              begin
                // a full buffer refuses the byte rather than lose it
                s_nxt.ack_go = 1'b0;
              end
            end
          end
        end

        i2cto_pkg::ST_ACKW:
        begin
          if (scl_fall)
          begin
            s_nxt.sda_oe = s_r.ack_go;
            s_nxt.st     = s_r.ack_go ? i2cto_pkg::ST_ACK : i2cto_pkg::ST_IGNORE;
          end
        end

        i2cto_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            s_nxt.sda_oe  = 1'b0;
            s_nxt.bit_cnt = i2cto_pkg::BIT_RST;
            s_nxt.st      = i2cto_pkg::ST_RX;
            if (s_r.rd_dir)
              s_nxt = load_tx(s_nxt);
          end
        end

        i2cto_pkg::ST_TX:
        begin
          if (scl_rise)
          begin
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7)
              s_nxt.st = i2cto_pkg::ST_MACK;
          end
          else if (scl_fall)
          begin
            // data changes only while the clock is low
            s_nxt.sda_oe = ~s_r.sh[7];
            s_nxt.sh     = {s_r.sh[6:0], 1'b0};
          end
        end

        i2cto_pkg::ST_MACK:
        begin
          if (scl_fall)
            s_nxt.sda_oe = 1'b0;
          else if (scl_rise)
            s_nxt.st = s_r.sda_s ? i2cto_pkg::ST_IGNORE : i2cto_pkg::ST_ACK;
        end

        i2cto_pkg::ST_IGNORE:
        begin
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      s_r <= RST_REC;
    else if (I_CE)
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // write stream buffer
  // ----------------------------------------
  // a push is gated with i_ce too; the buffer itself also holds while i_ce is low
  assign bif.in_valid  = push & I_CE;
  assign bif.in_data   = {s_r.ptr, byte_in};
  assign bif.out_ready = I_WR_READY;

  i2cto_buf u_buf
  (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_ce   (I_CE),
    .bif    (bif.fifo)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign O_SDA      = s_r.sda_o;
  assign O_SDA_OE   = s_r.sda_oe;
  assign O_RD_REQ   = s_r.rd_req;
  assign O_RD_ADDR  = s_r.rd_addr;
  assign O_WR_VALID = bif.out_valid;
  assign O_WR_ADDR  = bif.out_data[15:8];
  assign O_WR_DATA  = bif.out_data[7:0];

endmodule : i2cto_target

// ---- testbench/i2cto_ctrl_model.sv ----
// bus controller model: owns the serial clock, pulls the data wire low
// assumes the bench resolves the wire with a pull-up
`timescale 1ns/1ps
module i2cto_ctrl_model
(
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl = 1'b1,
  output logic      o_sda_oe = 1'b0
);
  // --------------
  // wire sequences
  // --------------
  task automatic drv(input logic c, input logic oe, input int n);
    o_scl <= c;
    o_sda_oe <= oe;
    repeat (n) @(posedge i_clk);
  endtask : drv
  // low 5 cycles, high 3: the target's late drive lands mid-low
  task automatic bit_io(input logic b, output logic s);
    drv(1'b0, !b, 4);
    drv(1'b1, !b, 2);
    s = i_sda;
    drv(1'b1, !b, 1);
    drv(1'b0, !b, 1);
  endtask : bit_io
  task automatic start_c();
    drv(o_scl, 1'b0, 4);
    drv(1'b1, 1'b0, 4);
    drv(1'b1, 1'b1, 4);
    drv(1'b0, 1'b1, 1);
  endtask : start_c
  task automatic stop_c();
    drv(1'b0, 1'b1, 4);
    drv(1'b1, 1'b1, 4);
    drv(1'b1, 1'b0, 8);
  endtask : stop_c
  task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ai, ao);
  endtask : xfer
endmodule : i2cto_ctrl_model

// ---- testbench/i2cto_target_asserts.sv ----
// property checker on the two-wire target's top-level ports
// assumes one core clock and synchronous active-high reset
`timescale 1ns/1ps
module i2cto_target_asserts
#(parameter int unsigned TIMEOUT_CYCLES = i2cto_pkg::TOUT_CYCLES)
(
  input wire logic       I_CLK,
  input wire logic       I_SRST,
  input wire logic       I_SCL,
  input wire logic       I_SDA,
  input wire logic       O_SDA,
  input wire logic       O_SDA_OE,
  input wire logic       I_BACKUP_POWER_STATE,
  input wire logic       O_WR_VALID,
  input wire logic [7:0] O_WR_ADDR,
  input wire logic [7:0] O_WR_DATA,
  input wire logic       I_WR_READY,
  input wire logic       O_RD_REQ,
  input wire logic [7:0] O_RD_ADDR
);
  // cycles since the last start on the raw lines, saturating
  logic        sda_r;
  logic [23:0] cnt_r;
  always_ff @(posedge I_CLK)
  begin
    sda_r <= I_SDA;
    cnt_r <= (I_SRST || (I_SCL && sda_r && !I_SDA)) ? 24'h0 : cnt_r + {23'h0, ~&cnt_r};
  end
  // ----------
  // properties
  // ----------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  property p_sda_low; O_SDA == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("drive value not low");
  property p_chg_low; $changed(O_SDA_OE) && !I_BACKUP_POWER_STATE |-> !I_SCL; endproperty
  a_chg_low: assert property (p_chg_low) else $error("data drive moved while clock high");
  property p_bkp; I_BACKUP_POWER_STATE [*4] |-> !O_SDA_OE; endproperty
  a_bkp: assert property (p_bkp) else $error("data line held on backup");
  property p_wr_hold; O_WR_VALID && !I_WR_READY |=> O_WR_VALID && $stable({O_WR_ADDR, O_WR_DATA}); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word lost while stalled");
  property p_rd_pulse; O_RD_REQ |=> !O_RD_REQ; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("fetch request longer than a cycle");
  property p_rd_addr; $changed(O_RD_ADDR) |-> O_RD_REQ; endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("fetch address moved without request");
  property p_wr_ack; $rose(O_WR_VALID) |-> ##[1:8] O_SDA_OE; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("stored byte not acknowledged");
  property p_tmo; cnt_r >= TIMEOUT_CYCLES + 8 |-> !O_SDA_OE; endproperty
  a_tmo: assert property (p_tmo) else $error("data driven after transaction timeout");
  c_full: cover property (O_WR_VALID && !I_WR_READY);
  c_fetch: cover property (O_RD_REQ);
  c_tmo: cover property (cnt_r == TIMEOUT_CYCLES);
endmodule : i2cto_target_asserts

bind i2cto_target i2cto_target_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_i2cto_target_asserts
(
  .I_CLK, .I_SRST, .I_SCL, .I_SDA, .O_SDA, .O_SDA_OE, .I_BACKUP_POWER_STATE,
  .O_WR_VALID, .O_WR_ADDR, .O_WR_DATA, .I_WR_READY, .O_RD_REQ, .O_RD_ADDR
);

// ---- testbench/testbench.sv ----
// self-checking bench for the two-wire target with bus timeout
// assumes the controller model and the bound property checker
`timescale 1ns/1ps
module testbench;
  localparam int unsigned TMO = 2000;
  localparam logic [7:0]  KEY = 8'h5A;
  logic        clk, srst, bkp, wr_rdy, rd_vld, scl, m_oe, sda_o, sda_oe, wr_vld, rd_req;
  logic [7:0]  rd_dat, wr_adr, wr_dat, rd_adr;
  logic [15:0] got[$];
  int          bad_count = 0;
  int          num_checks = 0;
  wire         sda = m_oe ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  i2cto_target #(.TIMEOUT_CYCLES(TMO)) i_i2cto_target
  (
    .I_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda),
    .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_BACKUP_POWER_STATE(bkp),
    .O_WR_VALID(wr_vld), .O_WR_ADDR(wr_adr), .O_WR_DATA(wr_dat), .I_WR_READY(wr_rdy),
    .O_RD_REQ(rd_req), .O_RD_ADDR(rd_adr), .I_RD_VALID(rd_vld), .I_RD_DATA(rd_dat)
  );
  i2cto_ctrl_model i_i2cto_ctrl_model
  (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe)
  );
  // register source answers one cycle after each fetch
  always @(posedge clk)
  begin
    rd_vld <= rd_req;
    rd_dat <= rd_adr ^ KEY;
    if (wr_vld && wr_rdy)
      got.push_back({wr_adr, wr_dat});
  end
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // -------
  // helpers
  // -------
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic xb(input logic [7:0] tx, input logic ai, input logic [7:0] ed, input logic ea);
    logic [7:0] d;
    logic       a;
    i_i2cto_ctrl_model.xfer(tx, ai, d, a);
    check({7'h0, d, a}, {7'h0, ed, ea});
  endtask : xb
  task automatic ckw(input logic [15:0] exp);
    check(got.size() > 0 ? got.pop_front() : 16'hXXXX, exp);
  endtask : ckw
  task automatic st();
    i_i2cto_ctrl_model.start_c();
  endtask : st
  task automatic sp();
    i_i2cto_ctrl_model.stop_c();
  endtask : sp
  // ---------
  // scenarios
  // ---------
  task automatic t_write();
    st();
    xb(8'hA2, 1'b1, 8'hA2, 1'b0);
    xb(8'h10, 1'b1, 8'h10, 1'b0);
    xb(8'h55, 1'b1, 8'h55, 1'b0);
    xb(8'h66, 1'b1, 8'h66, 1'b0);
    st();
    xb(8'hA4, 1'b1, 8'hA4, 1'b1);
    xb(8'h66, 1'b1, 8'h66, 1'b1);
    sp();
    ckw(16'h1055);
    ckw(16'h1166);
  endtask : t_write
  task automatic t_read();
    st();
    xb(8'hA2, 1'b1, 8'hA2, 1'b0);
    xb(8'h20, 1'b1, 8'h20, 1'b0);
    st();
    xb(8'hA3, 1'b1, 8'hA3, 1'b0);
    xb(8'hFF, 1'b0, 8'h20 ^ KEY, 1'b0);
    xb(8'hFF, 1'b0, 8'h21 ^ KEY, 1'b0);
    xb(8'hFF, 1'b1, 8'h22 ^ KEY, 1'b1);
    sp();
    st();
    xb(8'hA3, 1'b1, 8'hA3, 1'b0);
    xb(8'hFF, 1'b1, 8'h23 ^ KEY, 1'b1);
    sp();
  endtask : t_read
  task automatic t_full();
    wr_rdy <= 1'b0;
    st();
    xb(8'hA2, 1'b1, 8'hA2, 1'b0);
    xb(8'h40, 1'b1, 8'h40, 1'b0);
    xb(8'h01, 1'b1, 8'h01, 1'b0);
    xb(8'h02, 1'b1, 8'h02, 1'b0);
    xb(8'h03, 1'b1, 8'h03, 1'b1);
    sp();
    wr_rdy <= 1'b1;
    repeat (4) @(posedge clk);
    ckw(16'h4001);
    ckw(16'h4102);
    check(16'(got.size()), 16'h0000);
  endtask : t_full
  task automatic t_tmo();
    st();
    xb(8'hA2, 1'b1, 8'hA2, 1'b0);
    xb(8'h50, 1'b1, 8'h50, 1'b0);
    repeat (TMO + 50) @(posedge clk);
    xb(8'h77, 1'b1, 8'h77, 1'b1);
    xb(8'hFF, 1'b1, 8'hFF, 1'b1);
    st();
    xb(8'hA3, 1'b1, 8'hA3, 1'b0);
    xb(8'hFF, 1'b1, 8'h50 ^ KEY, 1'b1);
    sp();
  endtask : t_tmo
  task automatic t_bkp();
    st();
    xb(8'hA2, 1'b1, 8'hA2, 1'b0);
    bkp <= 1'b1;
    repeat (10) @(posedge clk);
    bkp <= 1'b0;
    repeat (4) @(posedge clk);
    xb(8'h30, 1'b1, 8'h30, 1'b1);
    sp();
    st();
    xb(8'hA3, 1'b1, 8'hA3, 1'b0);
    xb(8'hFF, 1'b1, 8'h51 ^ KEY, 1'b1);
    sp();
  endtask : t_bkp
  // run long enough for every scenario, short enough to catch a hang
  initial
  begin
    #3_000_000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    srst = 1'b1;
    bkp = 1'b0;
    wr_rdy = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_write();
    t_read();
    t_full();
    t_tmo();
    t_bkp();
    report_and_stop();
  end
endmodule : testbench
